// ===== rtl/txrx_seq_pkg.sv
/*
 * constants shared by the packet transmit/receive sequencer: command codes,
 * irq flag bits, status byte fields and timing figures.
 * assumes a host command port and a modem event port outside the block.
 */
// What this block does
// - 16-bit step count; nonzero arms transmit timeout
// - after transmit done or timeout, go standby
// - count zero: receive one packet, then standby
// - count all ones: continuous receive, flag each
// - other count: standby on expiry or packet
// - receive-complete irq on every detected packet
// - sync, check-failure and timeout irqs in receive
// - clear command resets only masked flags
// - each pin is OR of mapped flags
// - error status byte bit layout
// - oversize flag when length exceeds maximum
// - check error flagged, packet still stored
// - aborted flag for receive and transmit
// - second byte: id, no-ack, id error
// - id error when id and checksum repeat
// - transmit finished flag means completion only
// - third byte holds correlator match code
// - sync strength captured at sync detection
// - buffer info returns length and offset
// - oversize variable packets are discarded
package txrx_seq_pkg;
   // host command codes (arbitrary encoding of this block's own port)
   localparam logic [3:0] CMD_START_TX      = 4'h1;
   localparam logic [3:0] CMD_START_RX      = 4'h2;
   localparam logic [3:0] CMD_STANDBY       = 4'h3;
   localparam logic [3:0] CMD_IRQ_ROUTING   = 4'h4;
   localparam logic [3:0] CMD_IRQ_CLEAR     = 4'h5;
   localparam logic [3:0] CMD_BASE_ADDR     = 4'h6;
   localparam logic [3:0] CMD_PKT_CONFIG    = 4'h7;
   // irq flag bit positions
   localparam int IRQ_W            = 16;
   localparam int IRQ_TX_DONE      = 0;
   localparam int IRQ_RX_DONE      = 1;
   localparam int IRQ_SYNC_MATCH   = 2;
   localparam int IRQ_CHECK_FAIL   = 6;
   localparam int IRQ_TIMEOUT      = 14;
   // status byte fields
   localparam int ERR_SYNC   = 6;
   localparam int ERR_LENGTH = 5;
   localparam int ERR_CHECK  = 4;
   localparam int ERR_ABORT  = 3;
   localparam int ERR_HEADER = 2;
   localparam int ERR_RXFIN  = 1;
   localparam int ERR_BUSY   = 0;
   localparam int PID_HI     = 7;
   localparam int PID_LO     = 6;
   localparam int PID_NOACK  = 5;
   localparam int PID_ERR    = 4;
   localparam int TX_FIN     = 0;
   // receive timeout modes by step count
   localparam logic [15:0] STEP_SINGLE     = 16'h0000;
   localparam logic [15:0] STEP_CONTINUOUS = 16'hFFFF;
   localparam logic [7:0]  STATUS_RESET    = 8'h00;
   // step size: base time unit in ns, counted at 50 MHz
   localparam int CLK_NS       = 20;
   localparam int STEP_UNIT_NS = 1000;
   localparam int STEP_CYCLES  = STEP_UNIT_NS / CLK_NS;
endpackage

// ===== rtl/step_timer.sv
/*
 * timeout timer: a one-cycle step tick from a divider, then a down counter
 * of steps. assumes load and stop come from the sequencer on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module step_timer #(
   parameter int STEP_CYCLES = txrx_seq_pkg::STEP_CYCLES
) (
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        load,
   input  wire logic [15:0] steps,
   input  wire logic        stop,
   output logic             expired
);
   typedef struct packed {
      logic [15:0] div;
      logic [15:0] count;
      logic        run;
      logic        expired;
   } timer_s;
   timer_s st_reg, st_next;

   always_comb begin
      st_next = st_reg;
      st_next.expired = 1'b0;
      if (load) begin
         st_next.div   = 16'h0000;
         st_next.count = steps;
         st_next.run   = (steps != 16'h0000);
      end else if (stop) begin
         st_next.run = 1'b0;
      end else if (st_reg.run) begin
         if (st_reg.div == 16'(STEP_CYCLES - 1)) begin
            st_next.div = 16'h0000;
            if (st_reg.count == 16'h0001) begin
               st_next.run     = 1'b0;
               st_next.expired = 1'b1;
            end
            st_next.count = st_reg.count - 16'h0001;
         end else begin
            st_next.div = st_reg.div + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign expired = st_reg.expired;
endmodule
`default_nettype wire

// ===== rtl/irq_flags.sv
/*
 * sticky interrupt flags with enable mask and three pin routing masks.
 * assumes events are one-cycle pulses; clear and routing come from the host.
 */
`timescale 1ns/1ps
`default_nettype none
module irq_flags #(
   parameter int W = txrx_seq_pkg::IRQ_W
) (
   input  wire logic         clk_sys,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] events,
   input  wire logic         clear,
   input  wire logic [W-1:0] clear_mask,
   input  wire logic         route_load,
   input  wire logic [W-1:0] enable_mask,
   input  wire logic [W-1:0] pin1_mask,
   input  wire logic [W-1:0] pin2_mask,
   input  wire logic [W-1:0] pin3_mask,
   output logic [W-1:0]      flags,
   output logic [2:0]        pins
);
   typedef struct packed {
      logic [W-1:0] flags;
      logic [W-1:0] en;
      logic [W-1:0] m1;
      logic [W-1:0] m2;
      logic [W-1:0] m3;
      logic [2:0]   pins;
   } irq_s;
   irq_s st_reg, st_next;
   logic [W-1:0] f;

   always_comb begin
      st_next = st_reg;
      if (route_load) begin
         st_next.en = enable_mask;
         st_next.m1 = pin1_mask;
         st_next.m2 = pin2_mask;
         st_next.m3 = pin3_mask;
      end
      // set wins over clear for an event in the clearing cycle
      f = st_reg.flags;
      if (clear) begin
         f = f & ~clear_mask;
      end
      f = f | (events & st_next.en);
      st_next.flags = f;
      st_next.pins = {|(f & st_next.m3), |(f & st_next.m2),
                      |(f & st_next.m1)};
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign flags = st_reg.flags;
   assign pins  = st_reg.pins;

   pins_follow_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      pins[0] == |(flags & st_reg.m1))
      else $error("pin one not the OR of its flags");
   clear_exact_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      clear && !route_load |=> ((flags & ~$past(flags)) ==
         (flags & ~$past(flags) & $past(events)))
         && ((($past(flags) & ~$past(clear_mask)) & ~flags) == '0))
      else $error("clear touched an unmasked flag");
endmodule
`default_nettype wire

// ===== rtl/packet_txrx_sequencer.sv
/*
 * operating-mode sequencer for transmit and receive: start commands with
 * step timeouts, three receive modes, irq events and packet status bytes.
 * assumes a host command strobe and single-cycle modem events on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module packet_txrx_sequencer #(
   parameter int STEP_CYCLES = txrx_seq_pkg::STEP_CYCLES,
   parameter int AW          = 8
) (
   input  wire logic          clk_sys,
   input  wire logic          sys_rst,
   // host command port
   input  wire logic          cmd_valid,
   input  wire logic [3:0]    cmd_code,
   input  wire logic [15:0]   cmd_arg0,
   input  wire logic [15:0]   cmd_arg1,
   input  wire logic [15:0]   cmd_arg2,
   input  wire logic [15:0]   cmd_arg3,
   // modem events
   input  wire logic          tx_packet_sent,
   input  wire logic          rx_sync_found,
   input  wire logic [2:0]    rx_correlator,
   input  wire logic [7:0]    rx_strength,
   input  wire logic          rx_header_seen,
   input  wire logic          rx_packet_end,
   input  wire logic [7:0]    rx_length,
   input  wire logic          rx_crc_bad,
   input  wire logic [15:0]   rx_checksum,
   input  wire logic [1:0]    rx_pid,
   input  wire logic          rx_no_ack,
   input  wire logic          link_abort,
   // outputs
   output logic               tx_active,
   output logic               rx_active,
   output logic               standby_rc_oscillator_mode,
   output logic               rx_store_enable,
   output logic [15:0]        irq_status,
   output logic               event_pin_one,
   output logic               event_pin_two,
   output logic               event_pin_three,
   output logic [7:0]         rx_error_status,
   output logic [7:0]         pid_and_tx_status,
   output logic [7:0]         sync_match_status,
   output logic [7:0]         sync_signal_strength,
   output logic [7:0]         received_length,
   output logic [AW-1:0]      rx_payload_offset
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_STANDBY = 2'b00,
      MODE_TX      = 2'b01,
      MODE_RX      = 2'b11
   } mode_e;

   typedef struct packed {
      mode_e          mode;
      logic           continuous;
      logic           in_packet;
      logic           variable_len;
      logic           pid_filter;
      logic [7:0]     max_len;
      logic [AW-1:0]  rx_base;
      logic           have_prev;
      logic [1:0]     prev_pid;
      logic [15:0]    prev_sum;
      logic [7:0]     err;
      logic [7:0]     pidst;
      logic [7:0]     syncst;
      logic [7:0]     strength;
      logic [7:0]     length;
      logic [AW-1:0]  offset;
      logic           store;
      logic           tx_on;
      logic           rx_on;
      logic           idle;
   } seq_s;
   seq_s st_reg, st_next;

   logic [15:0] ev;
   logic        timer_load;
   logic        timer_stop;
   logic        timer_expired;
   logic [15:0] flags;
   logic [2:0]  pins;
   logic [15:0] timer_steps;
   logic        oversize;
   logic        pid_repeat;

   wire start_tx = cmd_valid && cmd_code == txrx_seq_pkg::CMD_START_TX;
   wire start_rx = cmd_valid && cmd_code == txrx_seq_pkg::CMD_START_RX;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   step_timer #(.STEP_CYCLES(STEP_CYCLES)) u_timer (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .load    (timer_load),
      .steps   (timer_steps),
      .stop    (timer_stop),
      .expired (timer_expired)
   );

   irq_flags #(.W(txrx_seq_pkg::IRQ_W)) u_irq (
      .clk_sys     (clk_sys),
      .sys_rst     (sys_rst),
      .events      (ev),
      .clear       (cmd_valid && cmd_code == txrx_seq_pkg::CMD_IRQ_CLEAR),
      .clear_mask  (cmd_arg0),
      .route_load  (cmd_valid && cmd_code == txrx_seq_pkg::CMD_IRQ_ROUTING),
      .enable_mask (cmd_arg0),
      .pin1_mask   (cmd_arg1),
      .pin2_mask   (cmd_arg2),
      .pin3_mask   (cmd_arg3),
      .flags       (flags),
      .pins        (pins)
   );

   // ---------------------------------------------------------------
   // sequencing
   // ---------------------------------------------------------------
   always_comb begin
      // every start reloads, so a stale count never ends a new operation
      timer_load = start_tx || start_rx;
      // continuous receive loads a zero count, which arms nothing
      timer_steps = (start_rx && cmd_arg1 == txrx_seq_pkg::STEP_CONTINUOUS)
         ? 16'h0000 : cmd_arg1;
      // timer halts on packet detection so reception can finish
      timer_stop = st_reg.mode == MODE_RX && rx_sync_found;
      oversize = st_reg.variable_len && rx_length > st_reg.max_len;
      pid_repeat = st_reg.pid_filter && st_reg.have_prev
         && rx_pid == st_reg.prev_pid
         && rx_checksum == st_reg.prev_sum;
      ev = '0;
      st_next = st_reg;
      st_next.store = st_reg.store;
      case (st_reg.mode)
         MODE_STANDBY: begin
            st_next.err[txrx_seq_pkg::ERR_BUSY] = 1'b0;
         end
         MODE_TX: begin
            if (tx_packet_sent) begin
               ev[txrx_seq_pkg::IRQ_TX_DONE] = 1'b1;
               st_next.pidst[txrx_seq_pkg::TX_FIN] = 1'b1;
               st_next.err[txrx_seq_pkg::ERR_BUSY] = 1'b0;
               st_next.mode = MODE_STANDBY;
            end else if (timer_expired) begin
               ev[txrx_seq_pkg::IRQ_TIMEOUT] = 1'b1;
               st_next.err[txrx_seq_pkg::ERR_BUSY] = 1'b0;
               st_next.mode = MODE_STANDBY;
            end
            if (link_abort) begin
               st_next.err[txrx_seq_pkg::ERR_ABORT] = 1'b1;
            end
         end
         MODE_RX: begin
            if (rx_sync_found) begin
               ev[txrx_seq_pkg::IRQ_SYNC_MATCH] = 1'b1;
               st_next.in_packet = 1'b1;
               st_next.strength = rx_strength;
               st_next.syncst = {5'h00, rx_correlator};
               st_next.err[txrx_seq_pkg::ERR_BUSY] = 1'b1;
               st_next.store = 1'b1;
            end
            if (rx_header_seen && st_reg.variable_len) begin
               st_next.err[txrx_seq_pkg::ERR_HEADER] = 1'b1;
               st_next.store = !oversize;
            end
            if (link_abort) begin
               st_next.err[txrx_seq_pkg::ERR_ABORT] = 1'b1;
            end
            if (rx_packet_end) begin
               // fires on every packet whatever its length or check
               ev[txrx_seq_pkg::IRQ_RX_DONE] = 1'b1;
               ev[txrx_seq_pkg::IRQ_CHECK_FAIL] = rx_crc_bad;
               st_next.err[txrx_seq_pkg::ERR_RXFIN] = 1'b1;
               st_next.err[txrx_seq_pkg::ERR_BUSY] = 1'b0;
               st_next.err[txrx_seq_pkg::ERR_LENGTH] = oversize;
               // a bad check keeps the packet in the buffer
               st_next.err[txrx_seq_pkg::ERR_CHECK] = rx_crc_bad;
               st_next.err[txrx_seq_pkg::ERR_SYNC] = rx_correlator == 3'h0;
               st_next.pidst = {rx_pid, rx_no_ack, pid_repeat,
                                4'h0};
               st_next.have_prev = 1'b1;
               st_next.prev_pid = rx_pid;
               st_next.prev_sum = rx_checksum;
               st_next.in_packet = 1'b0;
               st_next.store = 1'b0;
               if (!oversize) begin
                  st_next.length = rx_length;
                  st_next.offset = st_reg.rx_base;
               end
               if (!st_reg.continuous) begin
                  st_next.mode = MODE_STANDBY;
               end
            end else if (timer_expired && !st_reg.in_packet) begin
               ev[txrx_seq_pkg::IRQ_TIMEOUT] = 1'b1;
               st_next.mode = MODE_STANDBY;
            end
         end
         default: begin
            st_next.mode = MODE_STANDBY;
         end
      endcase
      // host commands take precedence over modem events
      if (cmd_valid) begin
         case (cmd_code)
            txrx_seq_pkg::CMD_START_TX: begin
               st_next.mode = MODE_TX;
               st_next.err = {7'h00, 1'b1};
               st_next.pidst = txrx_seq_pkg::STATUS_RESET;
               st_next.store = 1'b0;
            end
            txrx_seq_pkg::CMD_START_RX: begin
               st_next.mode = MODE_RX;
               st_next.continuous =
                  cmd_arg1 == txrx_seq_pkg::STEP_CONTINUOUS;
               st_next.in_packet = 1'b0;
               st_next.err = txrx_seq_pkg::STATUS_RESET;
               st_next.store = 1'b0;
            end
            txrx_seq_pkg::CMD_STANDBY: begin
               st_next.mode = MODE_STANDBY;
               st_next.store = 1'b0;
               st_next.in_packet = 1'b0;
            end
            txrx_seq_pkg::CMD_BASE_ADDR: begin
               st_next.rx_base = cmd_arg0[AW-1:0];
            end
            txrx_seq_pkg::CMD_PKT_CONFIG: begin
               st_next.max_len = cmd_arg0[7:0];
               st_next.variable_len = cmd_arg1[0];
               st_next.pid_filter = cmd_arg1[1];
            end
            default: begin
            end
         endcase
      end
      // mode decode is registered so the mode outputs come from flops
      st_next.tx_on = st_next.mode == MODE_TX;
      st_next.rx_on = st_next.mode == MODE_RX;
      st_next.idle  = st_next.mode == MODE_STANDBY;
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_reg <= '0;
         st_reg.max_len <= 8'hFF;
         st_reg.idle <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign tx_active = st_reg.tx_on;
   assign rx_active = st_reg.rx_on;
   assign standby_rc_oscillator_mode = st_reg.idle;
   assign rx_store_enable = st_reg.store;
   assign irq_status = flags;
   assign event_pin_one = pins[0];
   assign event_pin_two = pins[1];
   assign event_pin_three = pins[2];
   assign rx_error_status = {1'b0, st_reg.err[6:0]};
   assign pid_and_tx_status = {st_reg.pidst[7:4], 3'h0,
                               st_reg.pidst[0]};
   assign sync_match_status = st_reg.syncst;
   assign sync_signal_strength = st_reg.strength;
   assign received_length = st_reg.length;
   assign rx_payload_offset = st_reg.offset;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   tx_done_standby_a: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      tx_active && tx_packet_sent && !cmd_valid |=>
         standby_rc_oscillator_mode && irq_status[0] == 1'b1
         || !$past(u_irq.st_reg.en[0]))
      else $error("transmit did not end in standby");
   rx_single_done_a: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      rx_active && !st_reg.continuous && rx_packet_end && !cmd_valid
         |=> standby_rc_oscillator_mode)
      else $error("single receive did not return to standby");
   rx_continuous_a: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      rx_active && st_reg.continuous && !cmd_valid |=> rx_active)
      else $error("continuous receive left receive mode");
   timer_stop_a: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      rx_active && rx_sync_found && !cmd_valid |=> !u_timer.st_reg.run)
      else $error("timer still running after detection");
   rx_done_ev_a: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      rx_active && rx_packet_end |-> ev[txrx_seq_pkg::IRQ_RX_DONE]
         && ev[txrx_seq_pkg::IRQ_CHECK_FAIL] == rx_crc_bad)
      else $error("receive events not raised");
   oversize_flag_a: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      rx_active && rx_packet_end && !cmd_valid |=>
         rx_error_status[5] == $past(oversize))
      else $error("oversize flag wrong");
   strength_hold_a: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      rx_active && rx_sync_found && !cmd_valid |=>
         sync_signal_strength == $past(rx_strength)
         && sync_match_status[2:0] == $past(rx_correlator))
      else $error("sync capture wrong");
   tx_fin_a: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      start_tx |=> pid_and_tx_status[0] == 1'b0
         && rx_error_status[0] == 1'b1)
      else $error("transmit start did not reset status");
   reserved_zero_a: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      rx_error_status[7] == 1'b0 && pid_and_tx_status[3:1] == 3'h0
      && sync_match_status[7:3] == 5'h00)
      else $error("reserved status bits not zero");
   cover_tx_c: cover property (@(posedge clk_sys) tx_active ##1
      standby_rc_oscillator_mode);
   cover_rx_cont_c: cover property (@(posedge clk_sys)
      rx_active && st_reg.continuous && rx_packet_end);
   cover_timeout_c: cover property (@(posedge clk_sys)
      rx_active && timer_expired);
   cover_discard_c: cover property (@(posedge clk_sys)
      rx_active && rx_header_seen && oversize);
   cover_pid_err_c: cover property (@(posedge clk_sys)
      rx_active && rx_packet_end && pid_repeat);
   tx_timeout_a: assert property (@(posedge clk_sys)
      disable iff (sys_rst)
      tx_active && timer_expired && !cmd_valid |=>
         standby_rc_oscillator_mode)
      else $error("transmit timeout did not end in standby");
endmodule
`default_nettype wire

// ===== dv/host_cmd_model.sv
/*
 * host command model: drives the sequencer's command port, one strobe
 * per call. assumes commands are taken on the rising edge of clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model (
   input  wire logic        clk_sys,
   output logic             cmd_valid,
   output logic [3:0]       cmd_code,
   output logic [15:0]      cmd_arg0,
   output logic [15:0]      cmd_arg1,
   output logic [15:0]      cmd_arg2,
   output logic [15:0]      cmd_arg3
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 4'h0;
      {cmd_arg0, cmd_arg1, cmd_arg2, cmd_arg3} = 64'h0;
   end
   // strobe drops at the next edge so two calls never merge into one
   task automatic send(input logic [3:0] c, input logic [15:0] a0, a1, a2);
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_arg0 <= a0;
      cmd_arg1 <= a1;
      cmd_arg2 <= a2;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== dv/packet_txrx_sequencer_tb_top.sv
/*
 * testbench for the transmit/receive sequencer: transmit, timeouts and
 * the three receive modes. assumes host_cmd_model on the command port.
 */
`timescale 1ns/1ps
`default_nettype none
module packet_txrx_sequencer_tb_top;
   logic        clk_sys, sys_rst, cv, bad, txa, rxa, sby, store, p1, p2, p3;
   logic [3:0]  cc;
   logic [15:0] a0, a1, a2, a3, irq, sum;
   logic [1:0]  pid;
   logic        nack;
   logic [4:0]  ev;
   logic [2:0]  corr;
   logic [7:0]  strg, len, est, pst, sst, sstr, rlen, roff;
   int          failures, tests_run;
   host_cmd_model host (.clk_sys(clk_sys), .cmd_valid(cv), .cmd_code(cc),
      .cmd_arg0(a0), .cmd_arg1(a1), .cmd_arg2(a2), .cmd_arg3(a3));
   // small step so the timed scenarios stay short
   packet_txrx_sequencer #(.STEP_CYCLES(2)) dut (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .cmd_valid(cv), .cmd_code(cc), .cmd_arg0(a0),
      .cmd_arg1(a1), .cmd_arg2(a2), .cmd_arg3(a3), .tx_packet_sent(ev[0]),
      .rx_sync_found(ev[1]), .rx_correlator(corr), .rx_strength(strg),
      .rx_header_seen(ev[2]), .rx_packet_end(ev[3]), .rx_length(len),
      .rx_crc_bad(bad), .rx_checksum(sum), .rx_pid(pid),
      .rx_no_ack(nack), .link_abort(ev[4]), .tx_active(txa),
      .rx_active(rxa), .standby_rc_oscillator_mode(sby),
      .rx_store_enable(store), .irq_status(irq), .event_pin_one(p1),
      .event_pin_two(p2), .event_pin_three(p3), .rx_error_status(est),
      .pid_and_tx_status(pst), .sync_match_status(sst),
      .sync_signal_strength(sstr), .received_length(rlen),
      .rx_payload_offset(roff));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic print_verdict();
      $display("failures=%0d tests_run=%0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one modem pulse with its data, all launched on one edge
   task automatic pulse(input int i, input logic [2:0] c,
                        input logic [7:0] s, l, input logic b);
      @(posedge clk_sys);
      ev[i] <= 1'b1;
      corr <= c;
      strg <= s;
      len <= l;
      bad <= b;
      @(posedge clk_sys);
      ev <= 5'h00;
   endtask
   task automatic settle();
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   task automatic wait_standby(input int bound);
      int n;
      n = 0;
      while (sby !== 1'b1 && n < bound) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (sby !== 1'b1) begin
         failures++;
         print_verdict();
      end
   endtask
   task automatic cmd(input logic [3:0] c, input logic [15:0] x, y);
      host.send(c, x, y, 16'h0000);
      settle();
   endtask
   task automatic tx_done();
      check(16'(est), 16'h0000);
      check({13'h0, p3, p2, p1}, 16'h0000);
      host.send(txrx_seq_pkg::CMD_IRQ_ROUTING, 16'hFFFF, 16'h4001,
                16'h0046);
      cmd(txrx_seq_pkg::CMD_BASE_ADDR, 16'h0040, 0);
      cmd(txrx_seq_pkg::CMD_START_TX, 0, 16'h0000);
      check(16'(txa), 16'h0001);
      pulse(0, 3'h0, 8'h00, 8'h00, 1'b0);
      settle();
      check(16'(sby), 16'h0001);
      check(irq, 16'h0001);
      check(16'(pst), 16'h0001);
      check({13'h0, p3, p2, p1}, 16'h0001);
      cmd(txrx_seq_pkg::CMD_IRQ_CLEAR, 16'h0002, 0);
      check(irq, 16'h0001);
      cmd(txrx_seq_pkg::CMD_IRQ_CLEAR, 16'h0001, 0);
      check(irq, 16'h0000);
      check(16'(p1), 16'h0000);
   endtask
   task automatic timeouts();
      cmd(txrx_seq_pkg::CMD_START_TX, 0, 16'h0003);
      wait_standby(40);
      check(irq, 16'h4000);
      cmd(txrx_seq_pkg::CMD_IRQ_CLEAR, 16'hFFFF, 0);
      cmd(txrx_seq_pkg::CMD_START_RX, 0, 16'h0003);
      wait_standby(40);
      check(irq, 16'h4000);
      cmd(txrx_seq_pkg::CMD_IRQ_CLEAR, 16'hFFFF, 0);
      // timer must freeze once sync is seen, well before expiry here
      cmd(txrx_seq_pkg::CMD_START_RX, 0, 16'h0005);
      pulse(1, 3'h4, 8'h10, 8'h00, 1'b0);
      repeat (12) @(posedge clk_sys);
      #1;
      check(16'(rxa), 16'h0001);
      pulse(3, 3'h4, 8'h10, 8'h08, 1'b0);
      settle();
      check(16'(sby), 16'h0001);
      cmd(txrx_seq_pkg::CMD_IRQ_CLEAR, 16'hFFFF, 0);
   endtask
   task automatic rx_single();
      cmd(txrx_seq_pkg::CMD_START_RX, 0, 16'h0000);
      pulse(1, 3'h2, 8'h50, 8'h00, 1'b0);
      settle();
      check(16'(sst), 16'h0002);
      check(16'(sstr), 16'h0050);
      check(irq, 16'h0004);
      check(16'(est[0]), 16'h0001);
      pulse(3, 3'h2, 8'h50, 8'h20, 1'b1);
      settle();
      check(16'(sby), 16'h0001);
      check(irq, 16'h0046);
      check(16'(est), 16'h0012);
      check(16'(rlen), 16'h0020);
      check(16'(roff), 16'h0040);
      check({13'h0, p3, p2, p1}, 16'h0002);
      cmd(txrx_seq_pkg::CMD_IRQ_CLEAR, 16'hFFFF, 0);
      check(16'(est), 16'h0012);
   endtask
   task automatic rx_continuous();
      cmd(txrx_seq_pkg::CMD_START_RX, 0, 16'hFFFF);
      for (int k = 0; k < 2; k++) begin
         pulse(1, 3'h1, 8'h30, 8'h00, 1'b0);
         pulse(3, 3'h1, 8'h30, 8'h10, 1'b0);
         settle();
         check(16'(rxa), 16'h0001);
         check(irq & 16'h0002, 16'h0002);
         cmd(txrx_seq_pkg::CMD_IRQ_CLEAR, 16'h0002, 0);
      end
      cmd(txrx_seq_pkg::CMD_STANDBY, 0, 0);
      check(16'(sby), 16'h0001);
   endtask
   task automatic rx_variable();
      cmd(txrx_seq_pkg::CMD_PKT_CONFIG, 16'h0010, 16'h0003);
      {pid, sum, nack} <= {2'h2, 16'hA5C3, 1'b1};
      for (int k = 0; k < 2; k++) begin
         cmd(txrx_seq_pkg::CMD_START_RX, 0, 16'h0000);
         pulse(1, 3'h1, 8'h30, 8'h00, 1'b0);
         pulse(2, 3'h1, 8'h30, 8'h10, 1'b0);
         #1;
         check(16'(store), 16'h0001);
         pulse(3, 3'h1, 8'h30, 8'h10, 1'b0);
         settle();
         check(16'(pst), {8'h00, 3'h5, 1'(k), 4'h0});
         check(16'(est), 16'h0006);
         check(16'(rlen), 16'h0010);
      end
      cmd(txrx_seq_pkg::CMD_START_RX, 0, 16'h0000);
      pulse(1, 3'h1, 8'h30, 8'h00, 1'b0);
      pulse(2, 3'h1, 8'h30, 8'h20, 1'b0);
      #1;
      check(16'(store), 16'h0000);
      pulse(4, 3'h1, 8'h30, 8'h20, 1'b0);
      pulse(3, 3'h1, 8'h30, 8'h20, 1'b0);
      settle();
      check(16'(est), 16'h002E);
      check(16'(rlen), 16'h0010);
      cmd(txrx_seq_pkg::CMD_IRQ_CLEAR, 16'hFFFF, 0);
   endtask
   initial begin
      failures = 0;
      tests_run = 0;
      sys_rst = 1'b1;
      ev = 5'h00;
      corr = 3'h0;
      {strg, len, bad, pid, sum, nack} = 36'h0;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      tx_done();
      timeouts();
      rx_single();
      rx_continuous();
      rx_variable();
      print_verdict();
   end
endmodule
`default_nettype wire
